/* verilog/cmil_top.sv */
// identity registers and protected control/lock bits on apb
// assumes a same-clock protection window input and flash byte
`timescale 1ns/1ps
`default_nettype none
`include "cmil_map.svh"

// How it works
// - three identity bytes, first at zero
// - maker byte fixed on every read
// - second byte gives flash size code
// - third byte gives part number code
// - revision upper nibble always reads zero
// - revision low nibble counts silicon revision
// - user code loaded from flash on the first clock edge after reset release
// - control bit zero disables test port
// - protected bits change only inside window
// - event bit four freezes channels 4-7
// - event bit zero freezes channels 0-3
// - waveform bit two freezes timer E0 unit
// - waveform bit zero freezes timer C0 unit
// - unused lock bits read as zero
module cmil_top #(
  parameter logic [7:0] MAKER_CODE = 8'h5A,  // arbitrary value
  parameter logic [7:0] FSIZE_CODE = 8'h3C,  // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h21,  // arbitrary value
  parameter logic [3:0] REV_CODE   = 4'h0    // 0 is the first spin
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // system side
  input  wire logic        ccp_open_i,      // change window open
  input  wire logic [7:0]  flash_ucode_i,   // user code from flash
  output logic             test_port_disable_o,
  output logic             lower_event_group_freeze_o,
  output logic             upper_event_group_freeze_o,
  output logic             timer_c0_waveform_freeze_o,
  output logic             timer_e0_waveform_freeze_o
);
  import cmil_pkg::*;

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  cmil_state_t st_q;      // slave phase
  cmil_state_t st_d;
  logic [31:0] rdata_q;   // read word held for the answer
  logic [31:0] rdata_d;
  logic        ready_q;   // answer strobe
  logic        ready_d;
  logic        err_q;     // unmapped address answer
  logic        err_d;

  logic        setup;     // first cycle of a transfer
  logic        wr_en;     // write takes effect this edge
  logic        hit;       // address maps to a register
  logic [31:0] rmux;      // read word for the current address
  logic        wr_ctrl;   // per-register write strobes
  logic        wr_evt;
  logic        wr_wave;

  // ----------------------------------------------------------------
  // register contents
  // ----------------------------------------------------------------
  cmil_byte_t  ctrl_q;    // chip_control
  cmil_byte_t  evt_q;     // event_channel_freeze
  cmil_byte_t  wave_q;    // waveform_ext_freeze
  cmil_byte_t  ucode_q;   // scan_chain_user_code
  cmil_byte_t  rev_byte;  // silicon_revision as read
  logic        ucode_ok;  // user code captured

  assign setup = psel_i && !penable_i;
  // the write lands on the same edge the master sees pready
  assign wr_en = psel_i && penable_i && ready_q && pwrite_i && !err_q;

  // upper nibble tied low, revision count below
  assign rev_byte = {4'h0, REV_CODE};

  // ----------------------------------------------------------------
  // address decode and read mux
  // ----------------------------------------------------------------
  // low two address bits are ignored; every register is a full word
  always_comb begin
    hit  = 1'b1;
    rmux = `CMIL_RST_WORD;
    case ({paddr_i[7:2], 2'b00})
      `CMIL_OFF_MAKER: begin
        rmux = {24'h0, MAKER_CODE};  // constant
      end
      `CMIL_OFF_FSIZE: begin
        rmux = {24'h0, FSIZE_CODE};  // flash size code
      end
      `CMIL_OFF_PARTN: begin
        rmux = {24'h0, PART_CODE};   // part number
      end
      `CMIL_OFF_UCODE: begin
        rmux = {24'h0, ucode_q};
      end
      `CMIL_OFF_REV: begin
        rmux = {24'h0, rev_byte & `CMIL_MASK_REV};
      end
      `CMIL_OFF_CTRL: begin
        rmux = {24'h0, ctrl_q};
      end
      `CMIL_OFF_EVT: begin
        rmux = {24'h0, evt_q};       // unused bits zero
      end
      `CMIL_OFF_WAVE: begin
        rmux = {24'h0, wave_q};      // unused bits zero
      end
      default: begin
        hit = 1'b0;                  // unmapped: error, zero data
      end
    endcase
  end

  // ----------------------------------------------------------------
  // write strobes to the protected registers
  // ----------------------------------------------------------------
  // read-only registers swallow writes without an error
  always_comb begin
    wr_ctrl = 1'b0;
    wr_evt  = 1'b0;
    wr_wave = 1'b0;
    if (wr_en) begin
      case ({paddr_i[7:2], 2'b00})
        `CMIL_OFF_CTRL: wr_ctrl = 1'b1;
        `CMIL_OFF_EVT:  wr_evt  = 1'b1;
        `CMIL_OFF_WAVE: wr_wave = 1'b1;
        default: begin
          wr_ctrl = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb phase machine: answer in the first access cycle
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    rdata_d = rdata_q;
    ready_d = 1'b0;
    err_d   = 1'b0;
    case (st_q)
      CMIL_ST_IDLE: begin
        if (setup) begin
          st_d    = CMIL_ST_SETUP;
          ready_d = 1'b1;
          err_d   = !hit;
          rdata_d = (pwrite_i || !hit) ? `CMIL_RST_WORD : rmux;
        end
      end
      CMIL_ST_SETUP: begin
        // access cycle with pready high; transfer ends here
        st_d = CMIL_ST_ANS;
      end
      CMIL_ST_ANS: begin
        // back-to-back setup is taken at once
        if (setup) begin
          st_d    = CMIL_ST_SETUP;
          ready_d = 1'b1;
          err_d   = !hit;
          rdata_d = (pwrite_i || !hit) ? `CMIL_RST_WORD : rmux;
        end else begin
          st_d = CMIL_ST_IDLE;
        end
      end
      default: begin
        st_d = CMIL_ST_IDLE;
      end
    endcase
  end

  // registered bus state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q    <= CMIL_ST_IDLE;
      rdata_q <= `CMIL_RST_WORD;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q   <= err_d;
    end
  end

  assign prdata_o  = rdata_q;
  assign pready_o  = ready_q;
  assign pslverr_o = err_q;

  // ----------------------------------------------------------------
  // protected registers
  // ----------------------------------------------------------------
  // test-port disable may be cleared again inside the window;
  // software is expected to keep reserved bits at zero
  cmil_prot_reg #(
    .MASK   (`CMIL_MASK_CTRL),
    .STICKY (1'b0)
  ) u_ctrl (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_ctrl),
    .open_i  (ccp_open_i),
    .wdata_i (pwdata_i[7:0]),
    .q_o     (ctrl_q)
  );

  // lock bits hold until reset
  cmil_prot_reg #(
    .MASK   (`CMIL_MASK_EVT),
    .STICKY (1'b1)
  ) u_evt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_evt),
    .open_i  (ccp_open_i),
    .wdata_i (pwdata_i[7:0]),
    .q_o     (evt_q)
  );

  cmil_prot_reg #(
    .MASK   (`CMIL_MASK_WAVE),
    .STICKY (1'b1)
  ) u_wave (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_wave),
    .open_i  (ccp_open_i),
    .wdata_i (pwdata_i[7:0]),
    .q_o     (wave_q)
  );

  // user code captured from flash after reset
  cmil_ucode_load u_ucode (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .flash_code_i (flash_ucode_i),
    .code_o       (ucode_q),
    .loaded_o     (ucode_ok)
  );

  // ----------------------------------------------------------------
  // control and freeze outputs, each a register bit
  // ----------------------------------------------------------------
  // the peripherals must ignore writes while their freeze is high
  assign test_port_disable_o        = ctrl_q[`CMIL_BIT_TPD];
  assign lower_event_group_freeze_o = evt_q[`CMIL_BIT_EVT_LO];
  assign upper_event_group_freeze_o = evt_q[`CMIL_BIT_EVT_HI];
  assign timer_c0_waveform_freeze_o = wave_q[`CMIL_BIT_WAVE_C0];
  assign timer_e0_waveform_freeze_o = wave_q[`CMIL_BIT_WAVE_E0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_maker_read: assert property (
    (setup && !pwrite_i && paddr_i == `CMIL_OFF_MAKER)
      |=> (pready_o && prdata_o == {24'h0, MAKER_CODE}))
    else $error("maker byte read wrong");

  a_fsize_read: assert property (
    (setup && !pwrite_i && paddr_i == `CMIL_OFF_FSIZE)
      |=> (prdata_o == {24'h0, FSIZE_CODE}))
    else $error("flash size byte read wrong");

  a_part_read: assert property (
    (setup && !pwrite_i && paddr_i == `CMIL_OFF_PARTN)
      |=> (prdata_o == {24'h0, PART_CODE}))
    else $error("part number byte read wrong");

  a_rev_read: assert property (
    (setup && !pwrite_i && paddr_i == `CMIL_OFF_REV)
      |=> (prdata_o[7:4] == 4'h0 && prdata_o[3:0] == REV_CODE))
    else $error("revision read wrong");

  a_ucode_read: assert property (
    (ucode_ok && setup && !pwrite_i && paddr_i == `CMIL_OFF_UCODE)
      |=> (prdata_o[7:0] == $past(flash_ucode_i, 2)) or
          (prdata_o[7:0] == ucode_q))
    else $error("user code read wrong");

  a_tpd_write: assert property (
    (wr_en && ccp_open_i && paddr_i == `CMIL_OFF_CTRL)
      |=> (test_port_disable_o == $past(pwdata_i[0])))
    else $error("test port disable not written");

  a_closed_write: assert property (
    (!ccp_open_i) |=> $stable({ctrl_q, evt_q, wave_q}))
    else $error("protected bits changed outside window");

  a_evt_reserved: assert property (
    (setup && !pwrite_i && paddr_i == `CMIL_OFF_EVT)
      |=> (prdata_o[7:5] == 3'h0 && prdata_o[3:1] == 3'h0))
    else $error("event lock reserved bits nonzero");

  a_wave_reserved: assert property (
    (setup && !pwrite_i && paddr_i == `CMIL_OFF_WAVE)
      |=> (prdata_o[7:3] == 5'h0 && prdata_o[1] == 1'b0))
    else $error("waveform lock reserved bits nonzero");

  a_freeze_stays: assert property (
    (upper_event_group_freeze_o || lower_event_group_freeze_o)
      |=> ($past(upper_event_group_freeze_o) <= upper_event_group_freeze_o)
       && ($past(lower_event_group_freeze_o) <= lower_event_group_freeze_o))
    else $error("event freeze released before reset");

  a_wave_stays: assert property (
    (timer_e0_waveform_freeze_o || timer_c0_waveform_freeze_o)
      |=> ($past(timer_e0_waveform_freeze_o) <= timer_e0_waveform_freeze_o)
       && ($past(timer_c0_waveform_freeze_o) <= timer_c0_waveform_freeze_o))
    else $error("waveform freeze released before reset");

  a_unmapped_err: assert property (
    (setup && !hit) |=> (pslverr_o && pready_o && prdata_o == 32'h0))
    else $error("unmapped address not refused");

endmodule

`default_nettype wire

/* shared/cmil_map.svh */
// constants of the control, identity and lock register bank
// assumes an apb slave with word aligned registers and 8-bit data
`ifndef CMIL_MAP_SVH
`define CMIL_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CMIL_OFF_MAKER 8'h00
`define CMIL_OFF_UCODE 8'h04
`define CMIL_OFF_FSIZE 8'h08
`define CMIL_OFF_PARTN 8'h0C
`define CMIL_OFF_REV   8'h10
`define CMIL_OFF_CTRL  8'h14
`define CMIL_OFF_EVT   8'h18
`define CMIL_OFF_WAVE  8'h1C

// ----------------------------------------------------------------
// field positions and implemented-bit masks
// ----------------------------------------------------------------
`define CMIL_BIT_TPD     0
`define CMIL_BIT_EVT_LO  0
`define CMIL_BIT_EVT_HI  4
`define CMIL_BIT_WAVE_C0 0
`define CMIL_BIT_WAVE_E0 2
`define CMIL_MASK_CTRL   8'h01
`define CMIL_MASK_EVT    8'h11
`define CMIL_MASK_WAVE   8'h05
`define CMIL_MASK_REV    8'h0F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CMIL_RST_REG   8'h00
`define CMIL_RST_WORD  32'h0000_0000

`endif

/* shared/cmil_pkg.sv */
// types shared by the control, identity and lock register bank
// assumes the constant header is compiled alongside
package cmil_pkg;

  // ----------------------------------------------------------------
  // apb slave phases, gray coded along idle -> setup -> answer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMIL_ST_IDLE  = 2'b00,
    CMIL_ST_SETUP = 2'b01,
    CMIL_ST_ANS   = 2'b11
  } cmil_state_t;

  typedef logic [7:0] cmil_byte_t;  // one register byte

endpackage

/* verilog/cmil_prot_reg.sv */
// one change-protected 8-bit control register
// assumes writes come as single-cycle strobes on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "cmil_map.svh"

module cmil_prot_reg #(
  parameter logic [7:0] MASK   = 8'h01,  // implemented bits
  parameter bit         STICKY = 1'b0    // set bits hold until reset
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,     // write strobe
  input  wire logic       open_i,   // protected window open
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] q_o
);
  import cmil_pkg::*;

  cmil_byte_t reg_q;  // stored bits
  cmil_byte_t reg_d;  // next value

  // ----------------------------------------------------------------
  // per-bit next value
  // ----------------------------------------------------------------
  for (genvar b = 0; b < 8; b++) begin : g_bit
    // unimplemented bits are constant zero whatever is written
    always_comb begin
      if (!MASK[b]) begin
        reg_d[b] = 1'b0;
      end else if (STICKY && reg_q[b]) begin
        reg_d[b] = 1'b1;  // a set lock cannot be undone
      end else if (wr_i && open_i) begin
        reg_d[b] = wdata_i[b];  // only inside the window
      end else begin
        reg_d[b] = reg_q[b];
      end
    end
  end

  // registered state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_q <= `CMIL_RST_REG;
    end else begin
      reg_q <= reg_d;
    end
  end

  assign q_o = reg_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_closed_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !open_i |=> $stable(reg_q))
    else $error("protected register changed outside the window");

  a_lock_keeps: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (STICKY && (reg_q != 8'h00)) |=> ((reg_q & $past(reg_q)) == $past(reg_q)))
    else $error("lock bit cleared before reset");

endmodule

`default_nettype wire

/* verilog/cmil_ucode_load.sv */
// scan-chain user code, captured from flash as reset is released
// assumes the flash byte is stable and on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "cmil_map.svh"

module cmil_ucode_load (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] flash_code_i,  // byte from flash
  output logic      [7:0] code_o,        // loaded user code
  output logic            loaded_o       // high once captured
);
  import cmil_pkg::*;

  cmil_byte_t code_q;
  cmil_byte_t code_d;
  logic       done_q;
  logic       done_d;

  // ----------------------------------------------------------------
  // capture once, on the first edge after release
  // ----------------------------------------------------------------
  // the async reset may only load a constant, so the flash value is
  // taken by the clock rather than during reset itself
  always_comb begin
    code_d = code_q;
    done_d = 1'b1;
    if (!done_q) begin
      code_d = flash_code_i;  // first-edge load after reset release
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_q <= `CMIL_RST_REG;
      done_q <= 1'b0;
    end else begin
      code_q <= code_d;
      done_q <= done_d;
    end
  end

  assign code_o   = code_q;
  assign loaded_o = done_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ucode_taken: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(done_q) |-> (code_q == $past(flash_code_i)))
    else $error("user code not taken from flash");

  a_ucode_frozen: assert property (
    @(posedge clk_i) disable iff (rst_i)
    done_q |=> $stable(code_q))
    else $error("user code changed after load");

endmodule

`default_nettype wire

/* sim/cmil_top_tb_top.sv */
// self-checking bench for the control, identity and lock register bank
// assumes the constant header and package are compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "cmil_map.svh"

module cmil_top_tb_top;

  // ----------------------------------------------------------------
  // identity values, arbitrary, differ from the design defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] MAKER = 8'h6B;  // arbitrary value
  localparam logic [7:0] FSIZE = 8'h47;  // arbitrary value
  localparam logic [7:0] PARTN = 8'h92;  // arbitrary value
  localparam logic [3:0] REV   = 4'h3;   // fourth spin
  localparam logic [7:0] UCODE = 8'hA7;  // flash byte at power-up

  // one transfer and what it should give; outs = {tpd, ev_lo, ev_hi, c0, e0}
  typedef struct packed {
    logic       wr;
    logic       ccp;
    logic [7:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic       err;
    logic [4:0] outs;
  } cmil_row_t;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        ccp_open_i = 1'b0;
  logic [7:0]  flash_ucode_i = UCODE;
  logic [4:0]  outs;  // gathered lock and disable outputs
  int          num_errors = 0;
  int          cmp_count = 0;
  logic [31:0] rd;
  logic        err;

  // ----------------------------------------------------------------
  // clock and design
  // ----------------------------------------------------------------
  always #20 clk_i = ~clk_i;  // 25 MHz

  cmil_top #(
    .MAKER_CODE (MAKER),
    .FSIZE_CODE (FSIZE),
    .PART_CODE  (PARTN),
    .REV_CODE   (REV)
  ) i_cmil_top (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .psel_i                     (psel_i),
    .penable_i                  (penable_i),
    .pwrite_i                   (pwrite_i),
    .paddr_i                    (paddr_i),
    .pwdata_i                   (pwdata_i),
    .prdata_o                   (prdata_o),
    .pready_o                   (pready_o),
    .pslverr_o                  (pslverr_o),
    .ccp_open_i                 (ccp_open_i),
    .flash_ucode_i              (flash_ucode_i),
    .test_port_disable_o        (outs[4]),
    .lower_event_group_freeze_o (outs[3]),
    .upper_event_group_freeze_o (outs[2]),
    .timer_c0_waveform_freeze_o (outs[1]),
    .timer_e0_waveform_freeze_o (outs[0])
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // verdict in one place, also reached from a hung transfer
  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one apb transfer; the window input is held through the whole request
  task automatic apb(input logic w, input logic c, input logic [7:0] a,
                     input logic [7:0] wd, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i     <= 1'b1;
    penable_i  <= 1'b0;
    pwrite_i   <= w;
    paddr_i    <= a;
    pwdata_i   <= {24'h00_0000, wd};
    ccp_open_i <= c;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    // slave may stretch; wait is bounded so a hang ends the run
    while (pready_o !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_i);
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i     <= 1'b0;
    penable_i  <= 1'b0;
    ccp_open_i <= 1'b0;
    if (n == 16) begin
      num_errors++;
      results();
    end
  endtask

  // ----------------------------------------------------------------
  // ordinary cases: reads, refused writes, protected writes, sticky locks
  // ----------------------------------------------------------------
  cmil_row_t rows [33] = '{
    '{1'b0, 1'b0, `CMIL_OFF_MAKER, 8'h00, MAKER, 1'b0, 5'h00},
    '{1'b0, 1'b0, 8'h01, 8'h00, MAKER, 1'b0, 5'h00},            // low bits ignored
    '{1'b0, 1'b0, `CMIL_OFF_UCODE, 8'h00, UCODE, 1'b0, 5'h00},
    '{1'b0, 1'b0, `CMIL_OFF_FSIZE, 8'h00, FSIZE, 1'b0, 5'h00},
    '{1'b0, 1'b0, `CMIL_OFF_PARTN, 8'h00, PARTN, 1'b0, 5'h00},
    '{1'b0, 1'b0, `CMIL_OFF_REV, 8'h00, {4'h0, REV}, 1'b0, 5'h00},
    '{1'b0, 1'b0, `CMIL_OFF_CTRL, 8'h00, 8'h00, 1'b0, 5'h00},
    '{1'b0, 1'b0, `CMIL_OFF_EVT, 8'h00, 8'h00, 1'b0, 5'h00},
    '{1'b0, 1'b0, `CMIL_OFF_WAVE, 8'h00, 8'h00, 1'b0, 5'h00},
    '{1'b1, 1'b1, `CMIL_OFF_MAKER, 8'hFF, 8'h00, 1'b0, 5'h00},
    '{1'b0, 1'b0, `CMIL_OFF_MAKER, 8'h00, MAKER, 1'b0, 5'h00},
    '{1'b1, 1'b1, `CMIL_OFF_REV, 8'hFF, 8'h00, 1'b0, 5'h00},
    '{1'b0, 1'b0, `CMIL_OFF_REV, 8'h00, {4'h0, REV}, 1'b0, 5'h00},
    '{1'b1, 1'b0, `CMIL_OFF_CTRL, 8'h01, 8'h00, 1'b0, 5'h00},
    '{1'b0, 1'b0, `CMIL_OFF_CTRL, 8'h00, 8'h00, 1'b0, 5'h00},
    '{1'b1, 1'b1, `CMIL_OFF_CTRL, 8'hFF, 8'h00, 1'b0, 5'h10},
    '{1'b0, 1'b0, `CMIL_OFF_CTRL, 8'h00, 8'h01, 1'b0, 5'h10},
    '{1'b1, 1'b1, `CMIL_OFF_EVT, 8'h01, 8'h00, 1'b0, 5'h18},
    '{1'b0, 1'b0, `CMIL_OFF_EVT, 8'h00, 8'h01, 1'b0, 5'h18},
    '{1'b1, 1'b1, `CMIL_OFF_EVT, 8'hF0, 8'h00, 1'b0, 5'h1C},
    '{1'b0, 1'b0, `CMIL_OFF_EVT, 8'h00, 8'h11, 1'b0, 5'h1C},
    '{1'b1, 1'b0, `CMIL_OFF_WAVE, 8'hFF, 8'h00, 1'b0, 5'h1C},
    '{1'b0, 1'b0, `CMIL_OFF_WAVE, 8'h00, 8'h00, 1'b0, 5'h1C},
    '{1'b1, 1'b1, `CMIL_OFF_WAVE, 8'hFF, 8'h00, 1'b0, 5'h1F},
    '{1'b0, 1'b0, `CMIL_OFF_WAVE, 8'h00, 8'h05, 1'b0, 5'h1F},
    '{1'b1, 1'b1, `CMIL_OFF_EVT, 8'h00, 8'h00, 1'b0, 5'h1F},
    '{1'b1, 1'b1, `CMIL_OFF_WAVE, 8'h00, 8'h00, 1'b0, 5'h1F},
    '{1'b0, 1'b0, `CMIL_OFF_EVT, 8'h00, 8'h11, 1'b0, 5'h1F},
    '{1'b0, 1'b0, `CMIL_OFF_WAVE, 8'h00, 8'h05, 1'b0, 5'h1F},
    '{1'b1, 1'b1, `CMIL_OFF_CTRL, 8'h00, 8'h00, 1'b0, 5'h0F},   // not sticky
    '{1'b0, 1'b0, `CMIL_OFF_CTRL, 8'h00, 8'h00, 1'b0, 5'h0F},
    '{1'b0, 1'b0, 8'h20, 8'h00, 8'h00, 1'b1, 5'h0F},            // unmapped read
    '{1'b1, 1'b1, 8'h20, 8'hFF, 8'h00, 1'b1, 5'h0F}             // unmapped write
  };

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].ccp, rows[i].addr, rows[i].wd, rd, err);
      if (!rows[i].wr) check(rd, {24'h00_0000, rows[i].rd}, "read data");
      check({31'h0, err}, {31'h0, rows[i].err}, "error response");
      @(negedge clk_i);
      check({27'h0, outs}, {27'h0, rows[i].outs}, "lock outputs");
    end
    // second reset in mid-run: locks drop and a new user code is taken
    // inputs move only just after a rising edge, never on the falling one
    @(posedge clk_i);
    flash_ucode_i <= 8'h3C;
    rst_i         <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({27'h0, outs}, 32'h0000_0000, "outputs in reset");
    check({30'h0, pready_o, pslverr_o}, 32'h0000_0000, "bus in reset");
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    // flash byte changes later; the loaded code must not follow it
    flash_ucode_i <= 8'hC3;
    apb(1'b0, 1'b0, `CMIL_OFF_UCODE, 8'h00, rd, err);
    check(rd, 32'h0000_003C, "user code reload");
    apb(1'b0, 1'b0, `CMIL_OFF_EVT, 8'h00, rd, err);
    check(rd, 32'h0000_0000, "lock cleared by reset");
    apb(1'b0, 1'b0, `CMIL_OFF_MAKER, 8'h00, rd, err);
    check(rd, {24'h00_0000, MAKER}, "maker after reset");
    results();
  end

endmodule

`default_nettype wire
